// ---- rtl/sctx_pkg.sv ----
// constants of the smart card transmit control block
// assumes an axi4-lite master, 32-bit data, 20-bit byte address
package sctx_pkg;
  // ***********************************************
  // register map: index, byte address = index * 4
  // ***********************************************
  localparam logic [19:0] CTL_IDX  = 20'h0FE06;
  localparam logic [19:0] DATA_IDX = 20'h0FE07;
  localparam logic [19:0] CFG_IDX  = 20'h0FE0B;
  localparam logic [19:0] CTL_ADDR  = {CTL_IDX[17:0], 2'b00};
  localparam logic [19:0] DATA_ADDR = {DATA_IDX[17:0], 2'b00};
  localparam logic [19:0] CFG_ADDR  = {CFG_IDX[17:0], 2'b00};
  // ***********************************************
  // control/status bit positions
  // ***********************************************
  localparam int B_TWO_WIRE = 7;
  localparam int B_FULL     = 5;
  localparam int B_EMPTY    = 4;
  localparam int B_UNDER    = 3;
  localparam int B_FINAL    = 2;
  localparam int B_DIR      = 1;
  localparam int B_BRK      = 0;
  // configuration bit positions
  localparam int C_SYNC   = 0;
  localparam int C_BLOCK  = 1;
  localparam int C_CRC_EN = 2;
  localparam int C_CRC16  = 3;
  localparam int C_IO     = 4;
  // ***********************************************
  // reset values, fifo, frame, checksum
  // ***********************************************
  localparam logic [7:0]  CTL_RST    = 8'h00;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam int          FIFO_DEPTH = 4;
  localparam logic [2:0]  FIFO_FULL  = 3'h4;
  localparam logic [3:0]  BIT_PAR    = 4'h9;
  localparam logic [3:0]  BIT_LAST   = 4'hB;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;
endpackage

// ---- rtl/sctx_top.sv ----
// smart card transmit control: fifo, serialiser, checksum, status
// assumes axi4-lite master on clk; card clock and io arrive async
//
// Functional notes
// R1 - sync two-wire mode drives firmware io bit; the code does so only while rlen_at_limit is high
// R2 - full flag while full, event on fill
// R3 - firmware never writes a full fifo
// R4 - empty flag mirrors fifo; transmit when queued
// R5 - block mode: empty after checksum sent
// R6 - character mode: empty after final character
// R7 - event when fifo runs empty
// R8 - underrun flag when empty without mark
// R9 - underrun clears on read, error interrupt
// R10 - firmware sets mark after last byte
// R11 - block mode appends checksum after mark
// R12 - direction bit selects transmit, enables engine
// R13 - firmware selects receive before interface switch
// R14 - direction change restarts checksum
// R15 - early receive waits for empty fifo
// R16 - break flag, clears on read, error
// R17 - data writes push into fifo
// R18 - data reads pop fifo entry
// R19 - control register resets to zero
// R20 - full/empty derived from occupancy count
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module sctx_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [19:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [19:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        card_clk,
  input  wire logic        io_in,
  output logic             io_out,
  output logic             io_oe,
  input  wire logic        rlen_at_limit,
  output logic             tx_event_irq,
  output logic             tx_error_irq
);
  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic [3:0][7:0] fifo;
    logic [1:0]      wp;
    logic [1:0]      rp;
    logic [2:0]      cnt;
    logic [7:0]      ctl;
    logic [7:0]      cfg;
    logic            pend_rx;
    logic            busy;
    logic            is_crc;
    logic [9:0]      sh;
    logic [3:0]      bitn;
    logic [15:0]     crc;
    logic [1:0]      crc_pend;
    logic            crc_sent;
    logic [2:0]      ck;
    logic [1:0]      iod;
    logic            io_out;
    logic            io_oe;
    logic            ev;
    logic            err;
    logic            awr;
    logic            bv;
    logic [1:0]      br;
    logic            arr;
    logic            rv;
    logic [1:0]      rr;
    logic [7:0]      rd;
    logic            live;
  } sctx_state_t;

  sctx_state_t s;
  sctx_state_t next_s;

  // one checksum byte step, msb first
  function automatic logic [15:0] sctx_crc(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ sctx_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    logic       tx_mode;
    logic       edge_ck;
    logic       manual;
    logic       push;
    logic       pop;
    logic       done;
    logic       need_crc;
    logic       empty;
    logic [7:0] b;
    edge_ck = s.ck[1] & ~s.ck[2];
    // R12 effective direction
    // R15 early receive held
    tx_mode = s.ctl[sctx_pkg::B_DIR] | s.pend_rx;
    // R1 firmware io bit source
    manual = s.cfg[sctx_pkg::C_SYNC] & s.ctl[sctx_pkg::B_TWO_WIRE] & rlen_at_limit;
    need_crc = s.cfg[sctx_pkg::C_BLOCK] & s.cfg[sctx_pkg::C_CRC_EN] & ~s.crc_sent;
    // R5 empty waits for checksum
    // R6 empty waits for final character
    empty = (s.cnt == 3'h0) && !(s.ctl[sctx_pkg::B_FINAL]
            && (s.busy || s.crc_pend != 2'h0 || need_crc));
    next_s = s;
    push = 1'b0;
    pop = 1'b0;
    done = 1'b0;
    b = 8'h00;
    next_s.ev = 1'b0;
    next_s.err = 1'b0;
    next_s.live = 1'b1; // no empty event for reset settling
    // card clock: ck[0] feeds ck[1] only, ck[2] keeps last level
    next_s.ck = {s.ck[1], s.ck[0], card_clk};
    next_s.iod = {s.iod[0], io_in};
    // bus write: address and data taken together
    next_s.awr = ~s.awr & awvalid & wvalid & ~s.bv;
    if (s.bv && bready) begin
      next_s.bv = 1'b0;
    end
    if (s.awr) begin
      next_s.bv = 1'b1;
      next_s.br = sctx_pkg::RESP_OK;
      if (awaddr == sctx_pkg::CTL_ADDR) begin
        if (wstrb[0]) begin
          next_s.ctl[sctx_pkg::B_TWO_WIRE] = wdata[sctx_pkg::B_TWO_WIRE];
          next_s.ctl[sctx_pkg::B_FINAL] = wdata[sctx_pkg::B_FINAL];
          next_s.ctl[sctx_pkg::B_DIR] = wdata[sctx_pkg::B_DIR];
          if (!wdata[sctx_pkg::B_FINAL]) begin
            next_s.crc_sent = 1'b0;
          end
          // R14 restart checksum
          if (wdata[sctx_pkg::B_DIR] != s.ctl[sctx_pkg::B_DIR]) begin
            next_s.crc = s.cfg[sctx_pkg::C_CRC16] ? sctx_pkg::CRC_INIT : 16'h0000;
            next_s.crc_sent = 1'b0;
            next_s.crc_pend = 2'h0;
          end
          // R15 defer receive until empty
          if (!wdata[sctx_pkg::B_DIR] && s.ctl[sctx_pkg::B_FINAL]
              && !s.ctl[sctx_pkg::B_EMPTY]) begin
            next_s.pend_rx = 1'b1;
          end
        end
      end else if (awaddr == sctx_pkg::DATA_ADDR) begin
        // R17 push written byte
        push = wstrb[0] && (s.cnt != sctx_pkg::FIFO_FULL);
        if (push) begin
          next_s.fifo[s.wp] = wdata[7:0];
          next_s.wp = s.wp + 2'h1;
        end
      end else if (awaddr == sctx_pkg::CFG_ADDR) begin
        if (wstrb[0]) begin
          next_s.cfg = {3'h0, wdata[4:0]};
        end
      end else begin
        next_s.br = sctx_pkg::RESP_ERR;
      end
    end
    // bus read
    next_s.arr = ~s.arr & arvalid & ~s.rv;
    if (s.rv && rready) begin
      next_s.rv = 1'b0;
    end
    if (s.arr) begin
      next_s.rv = 1'b1;
      next_s.rr = sctx_pkg::RESP_OK;
      next_s.rd = 8'h00;
      if (araddr == sctx_pkg::CTL_ADDR) begin
        next_s.rd = s.ctl;
        // R9 underrun clears on read
        // R16 break clears on read
        next_s.ctl[sctx_pkg::B_UNDER] = 1'b0;
        next_s.ctl[sctx_pkg::B_BRK] = 1'b0;
      end else if (araddr == sctx_pkg::DATA_ADDR) begin
        // R18 read pops entry
        next_s.rd = s.fifo[s.rp];
        pop = (s.cnt != 3'h0);
      end else if (araddr == sctx_pkg::CFG_ADDR) begin
        next_s.rd = s.cfg;
      end else begin
        next_s.rr = sctx_pkg::RESP_ERR;
      end
    end
    // serialiser: one bit per card clock rising edge
    if (manual) begin
      next_s.io_out = s.cfg[sctx_pkg::C_IO];
      next_s.io_oe = 1'b1;
    end else if (!tx_mode) begin
      next_s.io_oe = 1'b0;
      next_s.io_out = 1'b0;
    end else if (edge_ck && s.busy) begin
      next_s.bitn = s.bitn + 4'h1;
      if (s.bitn < sctx_pkg::BIT_PAR) begin
        next_s.io_out = s.sh[1];
        next_s.sh = {1'b1, s.sh[9:1]};
      end else if (s.bitn == sctx_pkg::BIT_PAR) begin
        next_s.io_oe = 1'b0;
      end else if (s.bitn == sctx_pkg::BIT_LAST) begin
        next_s.busy = 1'b0;
        done = 1'b1;
      end
    end else if (edge_ck && !pop && (s.cnt != 3'h0 || s.crc_pend != 2'h0)) begin
      // R4 queued data sent
      if (s.crc_pend != 2'h0) begin
        b = (s.cfg[sctx_pkg::C_CRC16] && s.crc_pend == 2'h2) ? s.crc[15:8] : s.crc[7:0];
        next_s.crc_pend = s.crc_pend - 2'h1;
        next_s.is_crc = 1'b1;
      end else begin
        b = s.fifo[s.rp];
        pop = 1'b1;
        next_s.is_crc = 1'b0;
        next_s.crc = s.cfg[sctx_pkg::C_CRC16] ? sctx_crc(s.crc, b)
                                              : {8'h00, s.crc[7:0] ^ b};
      end
      next_s.sh = {^b, b, 1'b0};
      next_s.io_out = 1'b0;
      next_s.io_oe = 1'b1;
      next_s.busy = 1'b1;
      next_s.bitn = 4'h0;
    end else if (!s.busy) begin
      next_s.io_out = 1'b1;
      next_s.io_oe = 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 2'h1;
    end
    // R20 occupancy count
    next_s.cnt = s.cnt + {2'h0, push} - {2'h0, pop};
    // end of character: card pulls guard low on parity error
    if (done) begin
      if (!s.iod[1]) begin
        // R16 break on guard
        next_s.ctl[sctx_pkg::B_BRK] = 1'b1;
        next_s.err = 1'b1;
      end else if (!s.is_crc && s.cnt == 3'h0) begin
        if (!s.ctl[sctx_pkg::B_FINAL]) begin
          // R8 underrun, nothing else
          next_s.ctl[sctx_pkg::B_UNDER] = 1'b1;
          next_s.err = 1'b1;
        end else if (need_crc) begin
          // R11 append checksum
          next_s.crc_pend = s.cfg[sctx_pkg::C_CRC16] ? 2'h2 : 2'h1;
          next_s.crc_sent = 1'b1;
        end
      end
    end
    next_s.ctl[sctx_pkg::B_EMPTY] = empty;
    next_s.ctl[sctx_pkg::B_FULL] = (s.cnt == sctx_pkg::FIFO_FULL);
    // R2 event on going full
    // R7 event on going empty
    if ((empty && !s.ctl[sctx_pkg::B_EMPTY] && s.live)
        || (s.cnt == sctx_pkg::FIFO_FULL && !s.ctl[sctx_pkg::B_FULL])) begin
      next_s.ev = 1'b1;
    end
    if (empty) begin
      next_s.pend_rx = 1'b0;
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  // R19 all zero after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs straight from the state
  assign awready = s.awr;
  assign wready = s.awr;
  assign bvalid = s.bv;
  assign bresp = s.br;
  assign arready = s.arr;
  assign rvalid = s.rv;
  assign rresp = s.rr;
  assign rdata = {24'h000000, s.rd};
  assign io_out = s.io_out;
  assign io_oe = s.io_oe;
  assign tx_event_irq = s.ev;
  assign tx_error_irq = s.err;
  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // end-of-character strobe for the read-clear check
  logic done_w;
  assign done_w = s.busy && (s.ck[1] & ~s.ck[2]) && s.bitn == sctx_pkg::BIT_LAST;

  a_full_flag: assert property (ce |=> s.ctl[sctx_pkg::B_FULL] == ($past(s.cnt) == 3'h4)) // R2
    else $error("full flag does not track occupancy");
  a_full_event: assert property (ce && s.cnt == 3'h4 && !s.ctl[sctx_pkg::B_FULL] |=> s.ev) // R2
    else $error("no event on fifo going full");
  a_under_error: assert property ($rose(s.ctl[sctx_pkg::B_UNDER]) |-> s.err) // R9
    else $error("underrun without error pulse");
  a_brk_error: assert property ($rose(s.ctl[sctx_pkg::B_BRK]) |-> s.err) // R16
    else $error("break without error pulse");
  a_rd_clear: assert property (ce && s.arr && araddr == sctx_pkg::CTL_ADDR && !done_w
    |=> !s.ctl[sctx_pkg::B_BRK]) // R16
    else $error("break flag survived read");
  a_manual_io: assert property (ce && s.cfg[0] && s.ctl[7] && rlen_at_limit
    |=> s.io_oe && s.io_out == $past(s.cfg[sctx_pkg::C_IO])) // R1
    else $error("io not taken from firmware bit");
  a_rx_release: assert property (ce && !s.ctl[1] && !s.pend_rx && !s.cfg[0] |=> !s.io_oe) // R12
    else $error("io driven in receive mode");
  a_empty_crc: assert property (s.crc_pend != 2'h0 && s.ctl[2] |-> !next_s.ctl[4]) // R5
    else $error("empty set before checksum sent");
  a_push_count: assert property (ce && s.awr && awaddr == sctx_pkg::DATA_ADDR && wstrb[0]
    && s.cnt < 3'h4 && !(s.arr && araddr == sctx_pkg::DATA_ADDR) && !s.busy && s.crc_pend == 2'h0
    && !(s.ck[1] & ~s.ck[2]) |=> s.cnt == $past(s.cnt) + 3'h1) // R17
    else $error("write did not push");
  a_bus_answer: assert property (ce && s.awr |=> s.bv) // R17
    else $error("write response missing");
endmodule

// ---- dv/sctx_card_model.sv ----
// card stand-in: free card clock, frame capture, optional break
// assumes the reader launches each bit after a card_clk rise
`timescale 1ns/1ps
module sctx_card_model (
  input  wire logic brk_req,
  input  wire logic io_out,
  input  wire logic io_oe,
  output logic      card_clk,
  output logic      io_in
);
  logic [7:0] got[$];
  logic [8:0] sh;
  logic       pull_low = 1'b0;
  int         bit_n = 0;
  int         n_par_bad = 0;
  // card clock, free running, 64 ns
  initial card_clk = 1'b0;
  always #32 card_clk = ~card_clk;
  // line level: reader drive, else card pull-down, else pull-up
  assign io_in = io_oe ? io_out : !pull_low;
  // capture start, data lsb first, parity at each fall
  always @(negedge card_clk) begin
    if (bit_n == 0) begin
      if (io_oe === 1'b1 && io_out === 1'b0) bit_n = 1;
    end else begin
      sh = {io_out, sh[8:1]};
      bit_n++;
      if (bit_n == 10) begin
        got.push_back(sh[7:0]);
        n_par_bad += (^sh !== 1'b0);
        bit_n = 0;
        pull_low = brk_req;
      end
    end
  end
  // hold the break past the last guard sample
  always @(posedge pull_low) begin
    #180;
    pull_low = 1'b0;
  end
endmodule

// ---- dv/smart_card_tx_control_tb.sv ----
// bench for the smart card transmit block: bus tasks, card traffic
// assumes the card model and the design package
`timescale 1ns/1ps
module smart_card_tx_control_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, rlen_at_limit = 1'b0, brk_req = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [19:0] awaddr = 20'h00000, araddr = 20'h00000;
  logic [31:0] wdata = 32'h00000000, rdata, r32;
  logic        awready, wready, bvalid, arready, rvalid, card_clk, io_in, io_out, io_oe, ev, er;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] crc;
  int          n_fail = 0, checks = 0, n_ev = 0, n_er = 0, cyc = 0, e0;
  localparam logic [19:0] CTL = sctx_pkg::CTL_ADDR;
  localparam logic [19:0] DAT = sctx_pkg::DATA_ADDR;
  localparam logic [19:0] CFG = sctx_pkg::CFG_ADDR;

  sctx_top uut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .card_clk(card_clk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .rlen_at_limit(rlen_at_limit), .tx_event_irq(ev), .tx_error_irq(er));
  sctx_card_model card (.brk_req(brk_req), .io_out(io_out), .io_oe(io_oe),
    .card_clk(card_clk), .io_in(io_in));

  always #2 clk = ~clk;
  // count interrupt pulses, cut a hang short
  always @(posedge clk) begin
    n_ev <= n_ev + (ev === 1'b1);
    n_er <= n_er + (er === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ****************************************
  // bus tasks and compares
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic rd_reg(input logic [19:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rready <= 1'b0;
    r32 = rdata;
    rs = rresp;
  endtask
  task automatic rchk(input string what, input logic [19:0] a, input logic [7:0] e);
    rd_reg(a);
    chk(what, {24'h000000, e}, r32);
  endtask
  // wait for card bytes, then past the guard time
  task automatic wait_card(input int n, input int settle);
    while (card.got.size() < n) @(posedge clk);
    repeat (settle) @(posedge clk);
  endtask
  task automatic chk_card(input logic [7:0] e[$]);
    chk("card byte count", e.size(), card.got.size());
    foreach (e[i]) chk("card byte", e[i], card.got[i]);
    card.got.delete();
  endtask
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? sctx_pkg::CRC_POLY : 16'h0);
    return c;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("ctl after reset", CTL, 8'h10);
    chk("no event after reset", 0, n_ev);
    rd_reg(CFG + 20'h4);
    chk("unmapped read resp", sctx_pkg::RESP_ERR, rs);
    wr(CFG + 20'h4, 8'h55);
    chk("unmapped write resp", sctx_pkg::RESP_ERR, rs);
    // fill in receive mode, then pop
    for (int i = 0; i < 3; i++) wr(DAT, 8'(8'hA0 + i));
    rchk("ctl part full", CTL, 8'h00);
    e0 = n_ev;
    wr(DAT, 8'hA3); // fills, no further write
    rchk("ctl full", CTL, 8'h20);
    chk("full event", e0 + 1, n_ev);
    for (int i = 0; i < 4; i++) rchk("data pop", DAT, 8'(8'hA0 + i));
    rchk("ctl drained", CTL, 8'h10);
    chk("empty event", e0 + 2, n_ev);
    chk("silent in receive", 0, card.got.size());
    wr(DAT, 8'h5A);
    wr(DAT, 8'hC3);
    e0 = n_ev;
    wr(CTL, 8'h06);
    wr(CTL, 8'h04);
    wait_card(2, 200);
    chk_card('{8'h5A, 8'hC3});
    rchk("ctl after early rx", CTL, 8'h14);
    chk("line released", 0, io_oe);
    chk("send empty event", e0 + 1, n_ev);
    wr(CTL, 8'h02);
    e0 = n_er;
    wr(DAT, 8'h07);
    wait_card(1, 200);
    chk_card('{8'h07});
    rchk("underrun set", CTL, 8'h1A);
    chk("underrun error irq", e0 + 1, n_er);
    rchk("underrun cleared", CTL, 8'h12);
    // break from the card in guard time
    brk_req <= 1'b1;
    e0 = n_er;
    wr(DAT, 8'h3C);
    wr(CTL, 8'h06);
    wait_card(1, 200);
    brk_req <= 1'b0;
    chk_card('{8'h3C});
    rchk("break set", CTL, 8'h17);
    chk("break error irq", e0 + 1, n_er);
    rchk("break cleared", CTL, 8'h16);
    wr(CTL, 8'h00);
    wr(CFG, 8'h06);
    wr(DAT, 8'h12);
    wr(DAT, 8'h34);
    wr(CTL, 8'h06); // mark after final byte
    wait_card(2, 0);
    rchk("empty held for lrc", CTL, 8'h06);
    wait_card(3, 200);
    chk_card('{8'h12, 8'h34, 8'h26});
    rchk("ctl after lrc", CTL, 8'h16);
    wr(CTL, 8'h00);
    wr(CFG, 8'h0E);
    crc = crc_byte(crc_byte(sctx_pkg::CRC_INIT, 8'hF0), 8'h0F);
    wr(DAT, 8'hF0);
    wr(DAT, 8'h0F);
    wr(CTL, 8'h06);
    wait_card(4, 200);
    chk_card('{8'hF0, 8'h0F, crc[15:8], crc[7:0]});
    wr(CTL, 8'h80); // receive before source switch
    wr(CFG, 8'h11);
    rlen_at_limit <= 1'b1;
    repeat (4) @(posedge clk);
    chk("manual drive", 1, io_oe);
    chk("manual high", 1, io_out);
    wr(CFG, 8'h01);
    repeat (4) @(posedge clk);
    chk("manual low", 0, io_out);
    ce <= 1'b0;
    rlen_at_limit <= 1'b0;
    repeat (4) @(posedge clk);
    chk("frozen while ce low", 1, io_oe);
    chk("frozen level", 0, io_out);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    chk("no manual off limit", 0, io_oe);
    chk("card parity errors", 0, card.n_par_bad);
    tally_and_finish();
  end
endmodule
